// >>> pkg/ptm_defs.svh
// offsets, field positions and reset values of the product-term macrocell block
// assumes byte addressing on a 32-bit apb bus, one aligned word per register
`ifndef PTM_DEFS_SVH
`define PTM_DEFS_SVH

`define PTM_N_IN         32
`define PTM_N_MC         16
`define PTM_N_FB         9
`define PTM_N_GLB        4

// term masks: term t, word w at byte 16*t + 4*w, w = 0..2
`define PTM_MASK_BASE    12'h000
`define PTM_MASK_LAST    12'h1fc
`define PTM_MC_BASE      12'h200
`define PTM_MC_LAST      12'h23c
`define PTM_CTRL         12'h240
`define PTM_STAT         12'h244

// macrocell configuration word
`define PTM_MC_INV_T0    0
`define PTM_MC_XOR_POL   1
`define PTM_MC_LEND      2
`define PTM_MC_TYPE_LO   3
`define PTM_MC_BYPASS    5
`define PTM_MC_CLK_SEL   6
`define PTM_MC_CLR_LO    7
`define PTM_MC_W         9
`define PTM_MC_RST       9'h000

// block control word
`define PTM_CT_CLK0_SRC  0
`define PTM_CT_CLK1_SRC  2
`define PTM_CT_CLK0_FALL 4
`define PTM_CT_CLK1_FALL 5
`define PTM_CT_CLR0_LOC  6
`define PTM_CT_CLR1_LOC  7
`define PTM_CT_CLR0_INV  8
`define PTM_CT_CLR1_INV  9
`define PTM_CT_W         10
`define PTM_CT_RST       10'h000

`endif

// >>> pkg/ptm_pkg.sv
// types shared by the product-term macrocell block
// constants live in ptm_defs.svh
package ptm_pkg;

  typedef enum logic [1:0] {
    REG_D  = 2'b00,
    REG_T  = 2'b01,
    REG_JK = 2'b10,
    REG_SR = 2'b11
  } reg_type_e;

  typedef enum logic [1:0] {
    SRC_PIN    = 2'b00,
    SRC_GLOBAL = 2'b01,
    SRC_LOCAL  = 2'b10,
    SRC_RSVD   = 2'b11
  } clk_src_e;

  typedef enum logic [1:0] {
    CLR_NONE  = 2'b00,
    CLR_ZERO  = 2'b01,
    CLR_ONE   = 2'b10,
    CLR_NONE2 = 2'b11
  } clr_sel_e;

  typedef enum logic [2:0] {
    KIND_MASK = 3'b000,
    KIND_MC   = 3'b001,
    KIND_CTRL = 3'b010,
    KIND_STAT = 3'b011,
    KIND_NONE = 3'b100
  } reg_kind_e;

endpackage

// >>> logic/ptm_sync.sv
// two-flop synchroniser for a bus of independent levels
// assumes each bit is a slow level; no bit-to-bit coherence is promised
`timescale 1ns/100ps
module ptm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst_n,  // async reset, active low
  input  wire logic [W-1:0] d,      // asynchronous levels
  output logic      [W-1:0] q       // synchronised levels
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// >>> logic/ptm_macrocell.sv
// one macrocell: two product terms, select matrix, xor, programmable register
// assumes literals, ticks and clears are already synchronous to clk
`timescale 1ns/100ps
`include "ptm_defs.svh"
module ptm_macrocell #(
  parameter int NL = 82
) (
  input  wire logic                 clk,      // system clock
  input  wire logic                 rst_n,    // async reset, active low
  input  wire logic [NL-1:0]        lit,      // true and complement literals
  input  wire logic [NL-1:0]        mask0,    // literal select of term 0
  input  wire logic [NL-1:0]        mask1,    // literal select of term 1
  input  wire logic [`PTM_MC_W-1:0] cfg,      // macrocell configuration
  input  wire logic                 exp_in,   // expanders lent from upstream
  output logic                      exp_out,  // expanders lent downstream
  input  wire logic [1:0]           tick,     // gated edges of the two clocks
  input  wire logic [1:0]           clr,      // block clears, active high
  output logic                      mc_out    // macrocell output
);
  import ptm_pkg::*;

  logic      pt0, pt1, t0, two_in, lend, own, sum, my_tick, clr_hit, q_reg, q_next;
  reg_type_e rtype;
  clr_sel_e  csel;

  // an empty mask gives a term stuck at zero, so unused terms are harmless
  function automatic logic pterm(input logic [NL-1:0] m, input logic [NL-1:0] l);
    pterm = (|m) & (&(l | ~m));
  endfunction

  always_comb
  begin
    rtype   = reg_type_e'(cfg[`PTM_MC_TYPE_LO +: 2]);
    csel    = clr_sel_e'(cfg[`PTM_MC_CLR_LO +: 2]);
    lend    = cfg[`PTM_MC_LEND];
    pt0     = pterm(mask0, lit);
    pt1     = pterm(mask1, lit);
    t0      = pt0 ^ cfg[`PTM_MC_INV_T0];                                        // RULE6
    // jk and sr take term 1 as their second input instead of the or
    two_in  = !cfg[`PTM_MC_BYPASS] && (rtype == REG_JK || rtype == REG_SR);
    own     = lend ? 1'b0 : (t0 | (two_in ? 1'b0 : pt1));                      // RULE5 RULE16
    sum     = (own | (lend ? 1'b0 : exp_in)) ^ cfg[`PTM_MC_XOR_POL];            // RULE14
    // a lending cell passes its terms and everything upstream onward
    exp_out = lend ? (t0 | pt1 | exp_in) : 1'b0;                                // RULE5 RULE15
    my_tick = tick[cfg[`PTM_MC_CLK_SEL]];                                       // RULE9 RULE10
    clr_hit = (csel == CLR_ZERO && clr[0]) || (csel == CLR_ONE && clr[1]);      // RULE12
  end

  always_comb
  begin
    q_next = q_reg;
    if (clr_hit)
      q_next = 1'b0;
    else if (my_tick)
    begin
      case (rtype)                                                              // RULE7
        REG_D:   q_next = sum;
        REG_T:   q_next = q_reg ^ sum;
        REG_JK:  q_next = (sum & ~q_reg) | (~pt1 & q_reg);
        REG_SR:  q_next = sum ? 1'b1 : (pt1 ? 1'b0 : q_reg);
        default: q_next = q_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q_reg <= 1'b0;
    else
      q_reg <= q_next;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mc_out <= 1'b0;
    else
      mc_out <= cfg[`PTM_MC_BYPASS] ? sum : q_next;                             // RULE8 RULE4
  end

endmodule

// >>> logic/ptm_top.sv
// embedded_memory_block in product-term mode, configured over apb
// assumes all pin, global and local routing inputs are asynchronous levels
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
`include "ptm_defs.svh"
// Operation
// RULE1: the block takes 32 inputs from adjacent local routing.
// RULE2: nine macrocell outputs feed back into the block as term inputs.
// RULE3: control signals come from clock pins, global signals or local routing.
// RULE4: sixteen macrocells, each two product terms then one programmable register.
// RULE5: select matrix sends terms to own or-xor or lends them to neighbour.
// RULE6: one product term per macrocell may be inverted before combining.
// RULE7: each register acts as d, t, jk or sr flip-flop, clock selectable.
// RULE8: a macrocell may bypass its register and output its combinational result; here that result still goes through the mc_out flop on CLK_SYS.
// RULE9: each register uses one of two block-wide clocks, each source selectable.
// RULE10: each block clock has a paired enable; registers use only that enable.
// RULE11: mixed rising and falling edge registers use both block clocks.
// RULE12: two block clears from global or local; each register picks one or none.
// RULE13: each block clear may be inverted inside the block.
// RULE14: the or logic takes up to 32 terms, 30 lent by neighbours.
// RULE15: up to fifteen chained sets of two expanders, each adding delay.
// RULE16: a lent product term stops feeding its owning macrocell's or logic.
module ptm_top #(
  parameter int N_IN = `PTM_N_IN,
  parameter int N_MC = `PTM_N_MC,
  parameter int N_FB = `PTM_N_FB
) (
  input  wire logic                   CLK_SYS,     // system clock, 200 mhz
  input  wire logic                   RESETN,      // async reset, active low
  input  wire logic                   PSEL,        // apb select
  input  wire logic                   PENABLE,     // apb access phase
  input  wire logic                   PWRITE,      // apb direction
  input  wire logic [11:0]            PADDR,       // apb byte address
  input  wire logic [31:0]            PWDATA,      // apb write data
  output logic      [31:0]            PRDATA,      // apb read data
  output logic                        PREADY,      // apb ready
  output logic                        PSLVERR,     // apb error, unmapped address
  input  wire logic [N_IN-1:0]        PT_IN,       // local routing term inputs
  input  wire logic [1:0]             PIN_CLK,     // dedicated clock pins
  input  wire logic [`PTM_N_GLB-1:0]  GLOBAL_SIG,  // global signals
  input  wire logic [1:0]             LOCAL_CLK,   // local routing clocks
  input  wire logic [1:0]             LOCAL_CE,    // local routing clock enables
  input  wire logic [1:0]             LOCAL_CLR,   // local routing clears
  output logic      [N_MC-1:0]        MC_OUT       // macrocell outputs
);
  import ptm_pkg::*;

  localparam int NV = N_IN + N_FB;
  localparam int NL = 2 * NV;
  localparam int NT = 2 * N_MC;
  localparam int NA = N_IN + 2 + `PTM_N_GLB + 6;

  logic [NA-1:0]            async_in, sync_q;
  logic [N_IN-1:0]          pt_s;
  logic [1:0]               pin_clk_s, loc_clk_s, loc_ce_s, loc_clr_s;
  logic [`PTM_N_GLB-1:0]    glb_s;
  logic [NL-1:0]            mask_reg [0:NT-1];
  logic [`PTM_MC_W-1:0]     mc_cfg_reg [0:N_MC-1];
  logic [`PTM_CT_W-1:0]     ctrl_reg;
  logic [1:0]               clk_lvl, clk_prev_reg, tick, clr_lvl;
  logic [N_MC-1:0]          mc_q;
  logic [N_MC:0]            exp_chain;
  logic [NV-1:0]            in_vec;
  logic [NL-1:0]            lit;
  logic                     access, commit;
  reg_kind_e                rd_kind, wr_kind;
  logic [31:0]              rd_word;

  // every routing input is treated as foreign to CLK_SYS
  assign async_in = {LOCAL_CLR, LOCAL_CE, LOCAL_CLK, GLOBAL_SIG, PIN_CLK, PT_IN};

  ptm_sync #(
    .W (NA)
  ) u_sync (
    .clk   (CLK_SYS),
    .rst_n (RESETN),
    .d     (async_in),
    .q     (sync_q)
  );

  assign {loc_clr_s, loc_ce_s, loc_clk_s, glb_s, pin_clk_s, pt_s} = sync_q;

  // literal vector: term inputs plus fed-back outputs, true then complement
  assign in_vec = {MC_OUT[N_FB-1:0], pt_s};                                     // RULE1 RULE2
  assign lit    = {~in_vec, in_vec};

  function automatic logic pick_src(input logic [1:0] s, input logic p,
                                    input logic g, input logic l);
    case (clk_src_e'(s))
      SRC_GLOBAL: pick_src = g;
      SRC_LOCAL:  pick_src = l;
      default:    pick_src = p;
    endcase
  endfunction

  always_comb
  begin
    clk_lvl[0] = pick_src(ctrl_reg[`PTM_CT_CLK0_SRC +: 2], pin_clk_s[0],      // RULE3 RULE9
                          glb_s[0], loc_clk_s[0]);
    clk_lvl[1] = pick_src(ctrl_reg[`PTM_CT_CLK1_SRC +: 2], pin_clk_s[1],
                          glb_s[1], loc_clk_s[1]);
    clr_lvl[0] = (ctrl_reg[`PTM_CT_CLR0_LOC] ? loc_clr_s[0] : glb_s[2])
                 ^ ctrl_reg[`PTM_CT_CLR0_INV];                                  // RULE12 RULE13
    clr_lvl[1] = (ctrl_reg[`PTM_CT_CLR1_LOC] ? loc_clr_s[1] : glb_s[3])
                 ^ ctrl_reg[`PTM_CT_CLR1_INV];                                  // RULE12 RULE13
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
      clk_prev_reg <= 2'b00;
    else
      clk_prev_reg <= clk_lvl;
  end

  // each block clock has one edge polarity; mixed edges need both clocks
  always_comb
  begin
    tick[0] = (ctrl_reg[`PTM_CT_CLK0_FALL] ? (clk_prev_reg[0] & ~clk_lvl[0])   // RULE11
                                            : (~clk_prev_reg[0] & clk_lvl[0]))
              & loc_ce_s[0];                                                    // RULE10
    tick[1] = (ctrl_reg[`PTM_CT_CLK1_FALL] ? (clk_prev_reg[1] & ~clk_lvl[1])   // RULE11
                                            : (~clk_prev_reg[1] & clk_lvl[1]))
              & loc_ce_s[1];                                                    // RULE10
  end

  assign exp_chain[0] = 1'b0;

  // expanders flow from cell i to cell i+1; cell 15 may collect 15 sets
  genvar gi;
  generate
    for (gi = 0; gi < N_MC; gi++)
    begin : g_mc
      ptm_macrocell #(
        .NL (NL)
      ) u_mc (
        .clk     (CLK_SYS),
        .rst_n   (RESETN),
        .lit     (lit),
        .mask0   (mask_reg[2*gi]),
        .mask1   (mask_reg[2*gi+1]),
        .cfg     (mc_cfg_reg[gi]),
        .exp_in  (exp_chain[gi]),
        .exp_out (exp_chain[gi+1]),
        .tick    (tick),
        .clr     (clr_lvl),
        .mc_out  (mc_q[gi])
      );                                                                        // RULE4 RULE14 RULE15
    end
  endgenerate

  assign MC_OUT = mc_q;

  // address decode shared by read and write paths
  function automatic reg_kind_e decode(input logic [11:0] a);
    if (a[1:0] != 2'b00)
      decode = KIND_NONE;
    else if (a <= `PTM_MASK_LAST)
      decode = (a[3:2] == 2'b11) ? KIND_NONE : KIND_MASK;
    else if (a >= `PTM_MC_BASE && a <= `PTM_MC_LAST)
      decode = KIND_MC;
    else if (a == `PTM_CTRL)
      decode = KIND_CTRL;
    else if (a == `PTM_STAT)
      decode = KIND_STAT;
    else
      decode = KIND_NONE;
  endfunction

  // ready is registered, so every transfer spends exactly one wait cycle
  assign access  = PSEL & PENABLE & ~PREADY;
  assign commit  = PSEL & PENABLE & PREADY;
  assign rd_kind = decode(PADDR);
  assign wr_kind = rd_kind;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (rd_kind)
      KIND_MASK:
      begin
        case (PADDR[3:2])
          2'b00:   rd_word = mask_reg[PADDR[8:4]][31:0];
          2'b01:   rd_word = mask_reg[PADDR[8:4]][63:32];
          default: rd_word = {{(96-NL){1'b0}}, mask_reg[PADDR[8:4]][NL-1:64]};
        endcase
      end
      KIND_MC:   rd_word = {{(32-`PTM_MC_W){1'b0}}, mc_cfg_reg[PADDR[5:2]]};
      KIND_CTRL: rd_word = {{(32-`PTM_CT_W){1'b0}}, ctrl_reg};
      KIND_STAT: rd_word = {8'h00, loc_ce_s, clr_lvl, clk_lvl, tick, MC_OUT};
      default:   rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end
    else
    begin
      PREADY  <= access;
      PSLVERR <= access & (rd_kind == KIND_NONE);
      PRDATA  <= (access & ~PWRITE) ? rd_word : 32'h0000_0000;
    end
  end

  // writes land on the completing edge only; status writes are ignored
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int t = 0; t < NT; t++)
        mask_reg[t] <= '0;
    end
    else if (commit && PWRITE && wr_kind == KIND_MASK)
    begin
      case (PADDR[3:2])
        2'b00:   mask_reg[PADDR[8:4]][31:0]    <= PWDATA;
        2'b01:   mask_reg[PADDR[8:4]][63:32]   <= PWDATA;
        default: mask_reg[PADDR[8:4]][NL-1:64] <= PWDATA[NL-65:0];
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int m = 0; m < N_MC; m++)
        mc_cfg_reg[m] <= `PTM_MC_RST;
    end
    else if (commit && PWRITE && wr_kind == KIND_MC)
      mc_cfg_reg[PADDR[5:2]] <= PWDATA[`PTM_MC_W-1:0];
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
      ctrl_reg <= `PTM_CT_RST;
    else if (commit && PWRITE && wr_kind == KIND_CTRL)
      ctrl_reg <= PWDATA[`PTM_CT_W-1:0];
  end

endmodule

// >>> verification/ptm_top_props.sv
// assertions on the apb answer and output stability of ptm_top
// assumes it is bound to ptm_top and sees its ports only
`timescale 1ns/100ps
`include "ptm_defs.svh"
module ptm_top_props #(
  parameter int N_IN = `PTM_N_IN,
  parameter int N_MC = `PTM_N_MC
) (
  input wire logic                  CLK_SYS,    // system clock
  input wire logic                  RESETN,     // async reset, active low
  input wire logic                  PSEL,       // apb select
  input wire logic                  PENABLE,    // apb access phase
  input wire logic                  PWRITE,     // apb direction
  input wire logic [11:0]           PADDR,      // apb address
  input wire logic [31:0]           PWDATA,     // apb write data
  input wire logic [31:0]           PRDATA,     // apb read data
  input wire logic                  PREADY,     // apb ready
  input wire logic                  PSLVERR,    // apb error
  input wire logic [N_IN-1:0]       PT_IN,      // term inputs
  input wire logic [1:0]            PIN_CLK,    // clock pins
  input wire logic [`PTM_N_GLB-1:0] GLOBAL_SIG, // globals
  input wire logic [1:0]            LOCAL_CLK,  // local clocks
  input wire logic [1:0]            LOCAL_CE,   // clock enables
  input wire logic [1:0]            LOCAL_CLR,  // local clears
  input wire logic [N_MC-1:0]       MC_OUT      // macrocell outputs
);
  logic [N_IN+11:0] prev_reg;
  logic [4:0]       quiet_reg;
  wire  [N_IN+11:0] cur = {PT_IN, PIN_CLK, GLOBAL_SIG, LOCAL_CLK, LOCAL_CE, LOCAL_CLR};

  always_ff @(posedge CLK_SYS or negedge RESETN)
    if (!RESETN)
      prev_reg <= '0;
    else
      prev_reg <= cur;

  // restarts on any activity; long enough for every feedback chain to settle
  always_ff @(posedge CLK_SYS or negedge RESETN)
    if (!RESETN)
      quiet_reg <= '0;
    else if (PSEL || cur != prev_reg)
      quiet_reg <= '0;
    else if (quiet_reg != 5'h1f)
      quiet_reg <= quiet_reg + 5'h01;

  function automatic logic mapped(input logic [11:0] a);
    return a[1:0] == 2'h0 && ((a <= `PTM_MASK_LAST && a[3:2] != 2'h3) ||
           (a >= `PTM_MC_BASE && a <= `PTM_STAT));
  endfunction

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  sequence s_access;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_pulse;
    PREADY ##1 !PREADY;
  endsequence

  AST_ONE_WAIT: assert property (s_access |=> s_pulse)
    else $error("ready pulse missing after access");
  AST_READY_CAUSE: assert property ($rose(PREADY) |-> $past(PSEL) && $past(PENABLE))
    else $error("ready without access");
  AST_ERR_QUAL: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  AST_IDLE_RDATA: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside answer");
  AST_BAD_ADDR: assert property (s_access ##0 !mapped(PADDR) |=> PSLVERR && PRDATA == 32'h0)
    else $error("bad address not refused");
  AST_GOOD_ADDR: assert property (s_access ##0 mapped(PADDR) |=> !PSLVERR)
    else $error("mapped address refused");
  AST_WRITE_NO_DATA: assert property (s_access ##0 PWRITE |=> PRDATA == 32'h0)
    else $error("read data on a write");
  AST_QUIET_STABLE: assert property (quiet_reg == 5'h1f |-> $stable(MC_OUT))
    else $error("output moved with no cause");
endmodule

bind ptm_top ptm_top_props #(.N_IN(N_IN), .N_MC(N_MC)) u_props (
  .CLK_SYS, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
  .PSLVERR, .PT_IN, .PIN_CLK, .GLOBAL_SIG, .LOCAL_CLK, .LOCAL_CE, .LOCAL_CLR, .MC_OUT
);

// >>> verification/routing_model.sv
// logic array and local routing around the block: terms, clocks, enables, clears
// assumes one bench process calls its tasks, each just after a clock edge
`timescale 1ns/100ps
`include "ptm_defs.svh"
module routing_model (
  input  wire logic                  clk,        // system clock
  output logic      [31:0]           pt_in,      // term inputs
  output logic      [1:0]            pin_clk,    // clock pins
  output logic      [`PTM_N_GLB-1:0] global_sig, // globals
  output logic      [1:0]            local_clk,  // local clocks
  output logic      [1:0]            local_ce,   // clock enables
  output logic      [1:0]            local_clr   // local clears
);
  initial
  begin
    pt_in = '0;
    pin_clk = '0;
    global_sig = '0;
    local_clk = '0;
    local_ce = '0;
    local_clr = '0;
  end

  task automatic drive(input logic [31:0] v);
    @(posedge clk);
    pt_in <= v;
  endtask

  // src 0 pin, 1 global, 2 local; levels only, the block finds the edges
  task automatic clk_lvl(input int s, input int k, input logic v);
    @(posedge clk);
    case (s)
      0: pin_clk[k] <= v;
      1: global_sig[k] <= v;
      default: local_clk[k] <= v;
    endcase
  endtask

  task automatic ce(input logic [1:0] v);
    @(posedge clk);
    local_ce <= v;
  endtask

  task automatic clr(input logic [1:0] g, input logic [1:0] l);
    @(posedge clk);
    global_sig[3:2] <= g;
    local_clr <= l;
  endtask
endmodule

// >>> verification/ptm_top_tb.sv
// self-checking bench for ptm_top: apb map, term logic, expanders, registers
// assumes routing_model drives every routing input
`timescale 1ns/100ps
`include "ptm_defs.svh"
module ptm_top_tb;
  import ptm_pkg::*;
  localparam int SETTLE = 8;
  logic        CLK_SYS = 1'b0;
  logic        RESETN  = 1'b0;
  logic        PSEL    = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE  = 1'b0;
  logic [11:0] PADDR   = 12'h000;
  logic [31:0] PWDATA  = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [31:0] PT_IN;
  logic [1:0]  PIN_CLK;
  logic [3:0]  GLOBAL_SIG;
  logic [1:0]  LOCAL_CLK;
  logic [1:0]  LOCAL_CE;
  logic [1:0]  LOCAL_CLR;
  logic [15:0] MC_OUT;
  int          errors = 0;
  int          n_checks = 0;

  ptm_top DUT (.CLK_SYS, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .PT_IN, .PIN_CLK, .GLOBAL_SIG, .LOCAL_CLK, .LOCAL_CE,
    .LOCAL_CLR, .MC_OUT);
  routing_model u_rt (.clk(CLK_SYS), .pt_in(PT_IN), .pin_clk(PIN_CLK),
    .global_sig(GLOBAL_SIG), .local_clk(LOCAL_CLK), .local_ce(LOCAL_CE),
    .local_clr(LOCAL_CLR));

  initial
  begin
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic chk_mc(input int i, input logic x);
    n_checks++;
    if (MC_OUT[i] !== x)
    begin
      errors++;
      $display("FAIL mc_out[%0d] expected %b seen %b", i, x, MC_OUT[i]);
    end
  endtask

  // one setup cycle, then access held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1)
    begin
      errors++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk("write err", 32'h0, {31'h0, e});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk("read data", x, r);
    chk("read err", {31'h0, xe}, {31'h0, e});
  endtask

  function automatic logic [11:0] cfga(input int m);
    return 12'(`PTM_MC_BASE + 4 * m);
  endfunction

  function automatic logic [11:0] ma(input int t, input int w);
    return 12'(16 * t + 4 * w);
  endfunction

  task automatic settle;
    repeat (SETTLE) @(posedge CLK_SYS);
  endtask

  task automatic put(input logic [31:0] v);
    u_rt.drive(v);
    settle();
  endtask

  task automatic tick(input int s, input int k);
    u_rt.clk_lvl(s, k, 1'b1);
    settle();
    u_rt.clk_lvl(s, k, 1'b0);
    settle();
  endtask

  task automatic t_regs;
    rd(cfga(0), 32'h0, 1'b0);
    rd(`PTM_CTRL, 32'h0, 1'b0);
    rd(`PTM_STAT, 32'h0, 1'b0);
    // status is live state only, so a write must leave it alone and not be refused
    wr(`PTM_STAT, 32'hffffffff);
    rd(`PTM_STAT, 32'h0, 1'b0);
    wr(cfga(15), 32'hffffffff);
    rd(cfga(15), 32'h000001ff, 1'b0);
    wr(ma(3, 2), 32'hffffffff);
    rd(ma(3, 2), 32'h0003ffff, 1'b0);
    rd(ma(0, 3), 32'h0, 1'b1);
    rd(12'h248, 32'h0, 1'b1);
    rd(12'h202, 32'h0, 1'b1);
    wr(cfga(15), 32'h0);
    wr(ma(3, 2), 32'h0);
    $display("regs test done");
  endtask

  task automatic t_comb;
    wr(ma(0, 0), 32'h1);
    wr(ma(0, 2), 32'h100);
    for (int m = 0; m < 3; m++)
    begin
      wr(cfga(0), m == 0 ? 32'h20 : m == 1 ? 32'h21 : 32'h23);
      for (int b = 0; b < 4; b++)
      begin
        put({b[1], 30'h0, b[0]});
        chk_mc(0, (m == 1) ^ (b[0] & !b[1]));
      end
    end
    $display("comb test done");
  endtask

  task automatic t_lend;
    wr(ma(2, 0), 32'h2);
    wr(cfga(0), 32'h24);
    wr(cfga(1), 32'h24);
    wr(cfga(2), 32'h20);
    for (int b = 0; b < 4; b++)
    begin
      put({30'h0, b[1:0]});
      chk_mc(2, b != 0);
      chk_mc(1, 1'b0);
      chk_mc(0, 1'b0);
    end
    wr(cfga(1), 32'h20);
    settle();
    chk_mc(1, 1'b1);
    chk_mc(2, 1'b0);
    $display("lend test done");
  endtask

  task automatic t_fb;
    wr(ma(16, 0), 32'h8);
    wr(ma(18, 1), 32'h100);
    wr(cfga(8), 32'h20);
    wr(cfga(9), 32'h20);
    for (int b = 1; b >= 0; b--)
    begin
      put({28'h0, b[0], 3'h0});
      chk_mc(9, b[0]);
    end
    $display("feedback test done");
  endtask

  task automatic t_reg;
    logic [4:0] tab [9];
    logic       d;
    tab = '{{REG_T, 3'b100}, {REG_T, 3'b000}, {REG_JK, 3'b111}, {REG_JK, 3'b010},
            {REG_JK, 3'b101}, {REG_SR, 3'b010}, {REG_SR, 3'b111}, {REG_SR, 3'b001},
            {REG_D, 3'b000}};
    wr(ma(8, 0), 32'h4);
    wr(ma(9, 0), 32'h8);
    u_rt.ce(2'b01);
    for (int s = 0; s < 3; s++)
    begin
      d = (s % 2 == 0);
      wr(`PTM_CTRL, 32'(s));
      put({29'h0, d, 2'h0});
      tick(s, 0);
      chk_mc(4, d);
    end
    u_rt.ce(2'b10);
    put(32'h0);
    tick(2, 0);
    chk_mc(4, 1'b1);
    u_rt.ce(2'b01);
    for (int i = 0; i < 9; i++)
    begin
      wr(cfga(4), {27'h0, tab[i][4:3], 3'h0});
      put({28'h0, tab[i][1], tab[i][2], 2'h0});
      tick(2, 0);
      chk_mc(4, tab[i][0]);
    end
    $display("register test done");
  endtask

  task automatic t_edge_clr;
    wr(cfga(4), 32'h40);
    wr(`PTM_CTRL, 32'h22);
    u_rt.ce(2'b10);
    put(32'h4);
    u_rt.clk_lvl(0, 1, 1'b1);
    settle();
    chk_mc(4, 1'b0);
    u_rt.clk_lvl(0, 1, 1'b0);
    settle();
    chk_mc(4, 1'b1);
    wr(cfga(4), 32'hc0);
    u_rt.clr(2'b01, 2'b00);
    settle();
    chk_mc(4, 1'b0);
    u_rt.clr(2'b00, 2'b00);
    tick(0, 1);
    chk_mc(4, 1'b1);
    wr(`PTM_CTRL, 32'h122);
    settle();
    chk_mc(4, 1'b0);
    wr(cfga(4), 32'h140);
    wr(`PTM_CTRL, 32'h1a2);
    tick(0, 1);
    chk_mc(4, 1'b1);
    u_rt.clr(2'b00, 2'b10);
    settle();
    chk_mc(4, 1'b0);
    $display("edge and clear test done");
  endtask

  initial
  begin
    repeat (8) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    t_regs();
    t_comb();
    t_lend();
    t_fb();
    t_reg();
    t_edge_clr();
    repeat (40) @(posedge CLK_SYS);
    stop_test();
  end
endmodule
